// ---- verilog/uie_top.sv ----
// Purpose: USB interrupt status and enable registers with one request line
// Assumes: Bus condition and event inputs synchronous to sys_clk
// Notes:   Register port is 8 bits wide, read data one cycle after strobe
`timescale 1ns/1ps
module uie_top #(
  parameter int IDLE_COUNT = uie_pkg::IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Serial engine events and bus levels
  input  wire logic       stall_sent,
  input  wire logic       txn_done,
  input  wire logic [7:0] txn_stat_in,
  input  wire logic       sof_rcvd,
  input  wire logic [7:0] err_pulse,
  input  wire logic       bus_idle,
  input  wire logic       bus_kstate,
  input  wire logic       bus_se0,
  // Interrupt request
  output logic            usb_irq
);
  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  enbs;
    logic [7:0]  txn_stat;
    logic [7:0]  txn_hold;
    logic        hold_valid;
    logic [7:0]  rdata;
    logic        irq;
    // Check-only run lengths; synthesis drops them as unread
    logic [31:0] kstate_run;
    logic [31:0] se0_run;
    logic [31:0] idle_run;
    logic        busrst_seen;
  } uie_top_st_t;

  uie_top_st_t st_r;
  uie_top_st_t st_nxt;

  uie_evt_if idle_evt ();
  uie_evt_if resume_evt ();
  uie_evt_if busrst_evt ();

  logic [7:0] err_flags;
  logic [7:0] err_enbs;
  logic       err_any;
  logic [7:0] err_clr;
  logic       err_enb_we;
  logic       flags_wr;
  logic       enbs_wr;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic       tokdn_clr;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Saturating run length of a bus level; only the checks below read it
  function automatic logic [31:0] run_len(input logic lvl, input logic [31:0] cur);
    if (!lvl) begin
      run_len = 32'h0000_0000;
    end else if (cur == 32'hffff_ffff) begin
      run_len = cur;
    end else begin
      run_len = cur + 32'h0000_0001;
    end
  endfunction : run_len

  assign flags_wr   = reg_wr && hit(reg_addr, uie_pkg::OFS_FLAGS);
  assign enbs_wr    = reg_wr && hit(reg_addr, uie_pkg::OFS_ENABLES);
  assign err_enb_we = reg_wr && hit(reg_addr, uie_pkg::OFS_ERR_ENBS);
  assign err_clr    = (reg_wr && hit(reg_addr, uie_pkg::OFS_ERR_FLAGS)) ? reg_wdata : 8'h00;

  // Only bus_idle going low breaks the idle stretch; timer clears are tied low
  assign idle_evt.cond    = bus_idle;
  assign idle_evt.clear   = 1'b0;
  assign resume_evt.cond  = bus_kstate;
  assign resume_evt.clear = 1'b0;
  assign busrst_evt.cond  = bus_se0;
  assign busrst_evt.clear = 1'b0;

  uie_hold_timer #(.COUNT(IDLE_COUNT)) u_idle (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .evt     (idle_evt)
  );

  uie_hold_timer #(.COUNT(uie_pkg::RESUME_CYCLES)) u_resume (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .evt     (resume_evt)
  );

  uie_hold_timer #(.COUNT(uie_pkg::BUSRST_CYCLES)) u_busrst (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .evt     (busrst_evt)
  );

  uie_err_latch u_err (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .err_pulse (err_pulse),
    .clr_mask  (err_clr),
    .enb_we    (err_enb_we),
    .enb_wdata (reg_wdata),
    .err_flags (err_flags),
    .err_enbs  (err_enbs),
    .err_any   (err_any)
  );

  always_comb begin
    set_vec = 8'h00;
    set_vec[uie_pkg::BIT_STALL]  = stall_sent;
    set_vec[uie_pkg::BIT_RESUME] = resume_evt.hit;
    set_vec[uie_pkg::BIT_SLEEP]  = idle_evt.hit;
    set_vec[uie_pkg::BIT_TOKDN]  = txn_done;
    set_vec[uie_pkg::BIT_SOF]    = sof_rcvd;
    set_vec[uie_pkg::BIT_ERROR]  = err_any;
    set_vec[uie_pkg::BIT_BUSRST] = busrst_evt.hit;
  end

  assign clr_vec   = flags_wr ? reg_wdata : 8'h00;
  assign tokdn_clr = clr_vec[uie_pkg::BIT_TOKDN] && st_r.flags[uie_pkg::BIT_TOKDN];

  always_comb begin
    st_nxt = st_r;
    // Set wins over a same-cycle write-one clear
    st_nxt.flags = ((st_r.flags & ~clr_vec) | set_vec) & uie_pkg::IMPL_MASK;
    if (enbs_wr) begin
      st_nxt.enbs = reg_wdata & uie_pkg::IMPL_MASK;
    end
    // Status of a finished transaction; a second one waits in the holding entry
    if (tokdn_clr) begin
      if (st_r.hold_valid) begin
        st_nxt.txn_stat   = st_r.txn_hold;
        st_nxt.hold_valid = 1'b0;
        st_nxt.flags[uie_pkg::BIT_TOKDN] = 1'b1;
      end else begin
        st_nxt.txn_stat = 8'h00;
      end
    end
    if (txn_done) begin
      if (st_r.flags[uie_pkg::BIT_TOKDN] && !tokdn_clr) begin
        st_nxt.txn_hold   = txn_stat_in;
        st_nxt.hold_valid = 1'b1;
        // Holding entry is one deep; a third status overwrites it
      end else if (tokdn_clr && st_r.hold_valid) begin
        st_nxt.txn_hold   = txn_stat_in;
        st_nxt.hold_valid = 1'b1;
      end else begin
        st_nxt.txn_stat = txn_stat_in;
      end
    end
    st_nxt.irq = |(st_nxt.flags & st_nxt.enbs);
    st_nxt.kstate_run  = run_len(bus_kstate, st_r.kstate_run);
    st_nxt.se0_run     = run_len(bus_se0, st_r.se0_run);
    st_nxt.idle_run    = run_len(bus_idle, st_r.idle_run);
    st_nxt.busrst_seen = bus_se0 && (st_r.busrst_seen || busrst_evt.hit);
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        uie_pkg::OFS_FLAGS:     st_nxt.rdata = st_r.flags;
        uie_pkg::OFS_ENABLES:   st_nxt.rdata = st_r.enbs;
        uie_pkg::OFS_ERR_FLAGS: st_nxt.rdata = err_flags;
        uie_pkg::OFS_ERR_ENBS:  st_nxt.rdata = err_enbs;
        uie_pkg::OFS_TXN_STAT:  st_nxt.rdata = st_r.txn_stat;
        default:                st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r       <= '0;
      st_r.flags <= uie_pkg::RESET_FLAGS;
      st_r.enbs  <= uie_pkg::RESET_ENBS;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign usb_irq   = st_r.irq;

  // Assertions
  sequence s_clear_write(int b);
    flags_wr && reg_wdata[b];
  endsequence

  // Flag visible one cycle after the timer pulse
  sequence s_flag_next(int b);
    ##1 st_r.flags[b];
  endsequence

  property p_irq_or;
    @(posedge sys_clk) disable iff (!rstn)
      ##1 usb_irq == |($past(st_nxt.flags) & $past(st_nxt.enbs));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of enabled flags");

  property p_sticky;
    @(posedge sys_clk) disable iff (!rstn)
      (st_r.flags[uie_pkg::BIT_SOF] && !(flags_wr && reg_wdata[uie_pkg::BIT_SOF]))
        |=> st_r.flags[uie_pkg::BIT_SOF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write one");

  property p_w1c;
    @(posedge sys_clk) disable iff (!rstn)
      (s_clear_write(uie_pkg::BIT_STALL) ##0 !stall_sent) |=> !st_r.flags[uie_pkg::BIT_STALL];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_reset_zero;
    @(posedge sys_clk) !rstn |=> (st_r.flags == 8'h00) && (st_r.enbs == 8'h00) && !usb_irq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset");

  property p_stall_set;
    @(posedge sys_clk) disable iff (!rstn) stall_sent |=> st_r.flags[uie_pkg::BIT_STALL];
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall flag not set");

  property p_resume_time;
    @(posedge sys_clk) disable iff (!rstn)
      (bus_kstate && st_r.kstate_run == 32'(uie_pkg::RESUME_CYCLES - 1))
        |=> s_flag_next(uie_pkg::BIT_RESUME);
  endproperty
  a_resume_time: assert property (p_resume_time) else $error("resume flag late");

  property p_resume_hold;
    @(posedge sys_clk) disable iff (!rstn)
      resume_evt.hit |-> st_r.kstate_run == 32'(uie_pkg::RESUME_CYCLES);
  endproperty
  a_resume_hold: assert property (p_resume_hold) else $error("resume flag early");

  property p_sleep_time;
    @(posedge sys_clk) disable iff (!rstn)
      (bus_idle && st_r.idle_run == 32'(IDLE_COUNT - 1)) |=> s_flag_next(uie_pkg::BIT_SLEEP);
  endproperty
  a_sleep_time: assert property (p_sleep_time) else $error("idle flag late");

  property p_sleep_hold;
    @(posedge sys_clk) disable iff (!rstn)
      idle_evt.hit |-> st_r.idle_run == 32'(IDLE_COUNT);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("idle flag without unbroken idle");

  property p_busrst_once;
    @(posedge sys_clk) disable iff (!rstn)
      busrst_evt.hit |-> !st_r.busrst_seen;
  endproperty
  a_busrst_once: assert property (p_busrst_once) else $error("bus reset raised twice in one reset");

  property p_busrst_time;
    @(posedge sys_clk) disable iff (!rstn)
      (bus_se0 && st_r.se0_run == 32'(uie_pkg::BUSRST_CYCLES - 1)) |=> s_flag_next(uie_pkg::BIT_BUSRST);
  endproperty
  a_busrst_time: assert property (p_busrst_time) else $error("bus reset flag late");

  property p_busrst_hold;
    @(posedge sys_clk) disable iff (!rstn)
      busrst_evt.hit |-> $past(bus_se0, 1) && $past(bus_se0, 250);
  endproperty
  a_busrst_hold: assert property (p_busrst_hold) else $error("bus reset flag too early");

  property p_busrst_single;
    @(posedge sys_clk) disable iff (!rstn)
      (busrst_evt.hit && bus_se0) |=> !busrst_evt.hit;
  endproperty
  a_busrst_single: assert property (p_busrst_single) else $error("bus reset raised twice");

  property p_bit6;
    @(posedge sys_clk) disable iff (!rstn) !st_r.flags[6] && !st_r.enbs[6];
  endproperty
  a_bit6: assert property (p_bit6) else $error("bit six not zero");

  property p_tok_clear;
    @(posedge sys_clk) disable iff (!rstn)
      (tokdn_clr && !st_r.hold_valid && !txn_done) |=> st_r.txn_stat == 8'h00;
  endproperty
  a_tok_clear: assert property (p_tok_clear) else $error("status not cleared");

  property p_sof_set;
    @(posedge sys_clk) disable iff (!rstn) sof_rcvd |=> st_r.flags[uie_pkg::BIT_SOF];
  endproperty
  a_sof_set: assert property (p_sof_set) else $error("frame start flag not set");

  property p_enb_write;
    @(posedge sys_clk) disable iff (!rstn)
      enbs_wr |=> st_r.enbs == ($past(reg_wdata) & uie_pkg::IMPL_MASK);
  endproperty
  a_enb_write: assert property (p_enb_write) else $error("enable write not taken");

  property p_enb_read;
    @(posedge sys_clk) disable iff (!rstn)
      (reg_rd && reg_addr == uie_pkg::OFS_ENABLES) |=> reg_rdata == $past(st_r.enbs);
  endproperty
  a_enb_read: assert property (p_enb_read) else $error("enable read back wrong");

  property p_err_flag;
    @(posedge sys_clk) disable iff (!rstn) err_any |=> st_r.flags[uie_pkg::BIT_ERROR];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not set");

  property p_tok_set;
    @(posedge sys_clk) disable iff (!rstn) txn_done |=> st_r.flags[uie_pkg::BIT_TOKDN];
  endproperty
  a_tok_set: assert property (p_tok_set) else $error("done flag not set");

  property p_tok_reload;
    @(posedge sys_clk) disable iff (!rstn)
      (tokdn_clr && st_r.hold_valid)
        |=> st_r.flags[uie_pkg::BIT_TOKDN] && (st_r.txn_stat == $past(st_r.txn_hold));
  endproperty
  a_tok_reload: assert property (p_tok_reload) else $error("held status not loaded");

  property p_stall_rise;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(st_r.flags[uie_pkg::BIT_STALL]) |-> $past(stall_sent);
  endproperty
  a_stall_rise: assert property (p_stall_rise) else $error("stall flag set without stall");
endmodule : uie_top

// ---- pkg/uie_pkg.sv ----
// Purpose: Shared constants for the USB interrupt status and enable block
// Assumes: 200 MHz sys_clk, 8-bit register port
// Notes:   Offsets are register indices on the plain register port
package uie_pkg;
  localparam logic [3:0] OFS_FLAGS     = 4'h0;
  localparam logic [3:0] OFS_ENABLES   = 4'h1;
  localparam logic [3:0] OFS_ERR_FLAGS = 4'h2;
  localparam logic [3:0] OFS_ERR_ENBS  = 4'h3;
  localparam logic [3:0] OFS_TXN_STAT  = 4'h4;

  localparam int BIT_STALL  = 7;
  localparam int BIT_RESUME = 5;
  localparam int BIT_SLEEP  = 4;
  localparam int BIT_TOKDN  = 3;
  localparam int BIT_SOF    = 2;
  localparam int BIT_ERROR  = 1;
  localparam int BIT_BUSRST = 0;

  localparam logic [7:0] IMPL_MASK   = 8'hbf;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [7:0] RESET_ENBS  = 8'h00;

  localparam int CLK_MHZ       = 200;
  localparam int RESUME_NS     = 2500;
  localparam int BUSRST_NS     = 2500;
  localparam int IDLE_US       = 3000;
  localparam int RESUME_CYCLES = (RESUME_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSRST_CYCLES = (BUSRST_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CYCLES   = IDLE_US * CLK_MHZ;
endpackage : uie_pkg

// ---- pkg/uie_evt_if.sv ----
// Purpose: Carries bus condition levels to a timer and its event pulse back to the flag logic
// Assumes: Single sys_clk domain
// Notes:   Timer drives the qualified event pulses
`timescale 1ns/1ps
interface uie_evt_if;
  logic cond;
  logic clear;
  logic hit;
  modport timer (input cond, input clear, output hit);
  modport user  (output cond, output clear, input hit);
endinterface : uie_evt_if

// ---- verilog/uie_hold_timer.sv ----
// Purpose: Raises one pulse when a condition has held for a set count
// Assumes: Condition is synchronous to sys_clk
// Notes:   Pulse fires once per unbroken stretch of the condition
`timescale 1ns/1ps
module uie_hold_timer #(
  parameter int COUNT = 500
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Condition
  uie_evt_if.timer  evt
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
    logic        hit;
  } uie_ht_st_t;

  uie_ht_st_t st_r;
  uie_ht_st_t st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.hit = 1'b0;
    if (!evt.cond || evt.clear) begin
      // Any break restarts the count and re-arms the pulse
      st_nxt.cnt  = 32'h0;
      st_nxt.done = 1'b0;
    end else if (!st_r.done) begin
      if (st_r.cnt == 32'(COUNT - 1)) begin
        st_nxt.hit  = 1'b1;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.hit = st_r.hit;
endmodule : uie_hold_timer

// ---- verilog/uie_err_latch.sv ----
// Purpose: Sticky error source flags with enables and combined error
// Assumes: Error pulses synchronous to sys_clk
// Notes:   Set wins over a same-cycle clear
`timescale 1ns/1ps
module uie_err_latch (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Sources and software access
  input  wire logic [7:0] err_pulse,
  input  wire logic [7:0] clr_mask,
  input  wire logic       enb_we,
  input  wire logic [7:0] enb_wdata,
  // State
  output logic      [7:0] err_flags,
  output logic      [7:0] err_enbs,
  output logic            err_any
);
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enbs;
  } uie_el_st_t;

  uie_el_st_t st_r;
  uie_el_st_t st_nxt;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.flags = (st_r.flags & ~clr_mask) | err_pulse;
    if (enb_we) begin
      st_nxt.enbs = enb_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign err_flags = st_r.flags;
  assign err_enbs  = st_r.enbs;
  assign err_any   = |(st_r.flags & st_r.enbs);
endmodule : uie_err_latch

// ---- verification/uie_host_model.sv ----
// Purpose: Host side events and bus levels as seen through the serial engine
// Assumes: Single sys_clk domain, driven right after rising edges
// Notes:   Status bus shows the inverse of the last pulse value when not qualified
`timescale 1ns/1ps
module uie_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Engine events
  output logic            stall_sent  = 1'b0,
  output logic            txn_done    = 1'b0,
  output logic      [7:0] txn_stat_in = 8'h00,
  output logic            sof_rcvd    = 1'b0,
  output logic      [7:0] err_pulse   = 8'h00,
  // Bus levels
  output logic            bus_idle    = 1'b0,
  output logic            bus_kstate  = 1'b0,
  output logic            bus_se0     = 1'b0
);
  // One-cycle event: 0 stall, 1 transaction, 2 frame start, 3 error sources
  task automatic pulse(input int kind, input logic [7:0] v);
    @(posedge sys_clk);
    case (kind)
      0: stall_sent <= 1'b1;
      1: begin
        txn_done    <= 1'b1;
        txn_stat_in <= v;
      end
      2: sof_rcvd <= 1'b1;
      default: err_pulse <= v;
    endcase
    @(posedge sys_clk);
    stall_sent  <= 1'b0;
    txn_done    <= 1'b0;
    sof_rcvd    <= 1'b0;
    err_pulse   <= 8'h00;
    txn_stat_in <= ~v;
  endtask : pulse

  // Level held for n edges: 0 idle, 1 K state, any other value reset
  task automatic hold(input int which, input int n);
    @(posedge sys_clk);
    case (which)
      0: bus_idle <= 1'b1;
      1: bus_kstate <= 1'b1;
      default: bus_se0 <= 1'b1;
    endcase
    repeat (n) @(posedge sys_clk);
    bus_idle   <= 1'b0;
    bus_kstate <= 1'b0;
    bus_se0    <= 1'b0;
  endtask : hold
endmodule : uie_host_model

// ---- verification/usb_interrupt_status_enable_tb.sv ----
// Purpose: Register level tests of the flag and enable block
// Assumes: Idle count shortened to 20 cycles
// Notes:   Idle and resume timer edges probed a few cycles either side of the count
`timescale 1ns/1ps
module usb_interrupt_status_enable_tb;
  logic       sys_clk   = 1'b0;
  logic       rstn      = 1'b0;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic       usb_irq;
  logic       stall_sent, txn_done, sof_rcvd, bus_idle, bus_kstate, bus_se0;
  logic [7:0] txn_stat_in, err_pulse;
  int         n_fail    = 0;
  int         n_checks  = 0;

  uie_top #(.IDLE_COUNT(20)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stall_sent(stall_sent),
    .txn_done(txn_done), .txn_stat_in(txn_stat_in), .sof_rcvd(sof_rcvd), .err_pulse(err_pulse),
    .bus_idle(bus_idle), .bus_kstate(bus_kstate), .bus_se0(bus_se0), .usb_irq(usb_irq)
  );

  uie_host_model host (
    .sys_clk(sys_clk), .stall_sent(stall_sent), .txn_done(txn_done), .txn_stat_in(txn_stat_in),
    .sof_rcvd(sof_rcvd), .err_pulse(err_pulse), .bus_idle(bus_idle), .bus_kstate(bus_kstate),
    .bus_se0(bus_se0)
  );

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic exp);
    n_checks++;
    if (usb_irq !== exp) begin
      n_fail++;
      $display("mismatch %0t irq got %b exp %b", $time, usb_irq, exp);
    end
  endtask : chk1

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read, then compare the data in the one cycle it stands
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rc

  logic [7:0] m;

  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    rc(4'h0, 8'h00);
    rc(4'h1, 8'h00);
    rc(4'h5, 8'h00);
    wr(4'h1, 8'hff);
    rc(4'h1, 8'hbf);
    chk1(1'b0);
    for (int k = 0; k < 3; k += 2) begin
      m = (k == 0) ? 8'h80 : 8'h04;
      host.pulse(k, 8'h00);
      rc(4'h0, m);
      chk1(1'b1);
      wr(4'h0, 8'h40);
      rc(4'h0, m);
      wr(4'h0, m);
      rc(4'h0, 8'h00);
      chk1(1'b0);
    end
    host.pulse(0, 8'h00);
    wr(4'h1, 8'h7f);
    rc(4'h0, 8'h80);
    chk1(1'b0);
    // Resume stays masked until suspend is near
    wr(4'h1, 8'h9f);
    wr(4'h0, 8'h80);
    host.pulse(1, 8'h11);
    host.pulse(1, 8'h22);
    rc(4'h0, 8'h08);
    rc(4'h4, 8'h11);
    wr(4'h0, 8'h08);
    rc(4'h0, 8'h08);
    rc(4'h4, 8'h22);
    wr(4'h0, 8'h08);
    rc(4'h0, 8'h00);
    rc(4'h4, 8'h00);
    wr(4'h3, 8'h01);
    rc(4'h3, 8'h01);
    host.pulse(3, 8'h04);
    rc(4'h0, 8'h00);
    host.pulse(3, 8'h01);
    rc(4'h0, 8'h02);
    rc(4'h2, 8'h05);
    wr(4'h2, 8'h05);
    wr(4'h0, 8'h02);
    rc(4'h0, 8'h00);
    host.hold(0, 18);
    host.hold(0, 18);
    rc(4'h0, 8'h00);
    host.hold(0, 22);
    rc(4'h0, 8'h10);
    wr(4'h0, 8'h10);
    wr(4'h1, 8'hbf);
    host.hold(1, 498);
    rc(4'h0, 8'h00);
    host.hold(1, 502);
    rc(4'h0, 8'h20);
    chk1(1'b1);
    wr(4'h0, 8'h20);
    fork
      host.hold(2, 1200);
      begin
        repeat (600) @(posedge sys_clk);
        rc(4'h0, 8'h01);
        wr(4'h0, 8'h01);
        repeat (300) @(posedge sys_clk);
        rc(4'h0, 8'h00);
      end
    join
    host.hold(2, 502);
    rc(4'h0, 8'h01);
    chk1(1'b1);
    // Second reset in mid-run returns both registers to zero
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rc(4'h0, 8'h00);
    rc(4'h1, 8'h00);
    chk1(1'b0);
    final_report();
  end

  // Tests take about 2900 cycles
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule : usb_interrupt_status_enable_tb
